// >>> adcss_top.sv
// adcss_top: sweep sequencer for the converter (repeat sweep 0/1, simul)
// assumes an external core that converts one channel per start pulse
// and answers with a one-cycle done pulse and the result beside it
//
// Behaviour
// [RULE1] software trigger: writing start bit 1 begins the sequence
// [RULE2] hardware trigger: start bit arms; falling pin edge afterwards starts
// [RULE3] repeat sweep modes run until software clears the start bit
// [RULE4] repeat sweep 0 cycles channels 0..n-1, n is 2,4,6 or 8
// [RULE5] repeat sweep 1 puts a favoured channel before each other one
// [RULE6] repeat sweep 1 favoured set is channel 0, 0-1, 0-2 or 0-3
// [RULE7] group select moves the whole sweep to one eight-channel group
// [RULE8] each conversion result goes to that channel's result register
// [RULE9] simul mode samples channels 0 and 1 together, then converts each
// [RULE10] simul mode does one sweep of 2,4,6 or 8 channels from 0
// [RULE11] simul sweep end stops, raises done irq, clears start if software
// [RULE12] simul hardware trigger chosen by secondary and timer select bits
// [RULE13] timer underflows count only after the start bit is set
// [RULE14] timer select 1: first timer; else secondary 0 pin, 1 third timer; counter select 1 takes the freq counter instead
// [RULE15] clearing start aborts to idle, results kept
// [RULE16] repeat sweep modes never raise the done interrupt
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module adcss_top
  import adcss_pkg::*;
#(
  parameter int NCHAN = NCH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic external_trigger_pin_n,
  input wire logic first_timer_uf,
  input wire logic third_timer_uf,
  input wire logic freq_counter_uf,
  output logic conv_start,
  output logic [2:0] conv_channel,
  output logic [1:0] conv_group,
  output logic sample_hold_pair,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result,
  output logic irq
);
  localparam int CW = $clog2(NCHAN);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic start_q;
  logic trg_q;
  logic [1:0] mode_q;
  logic [1:0] scan_q;
  logic [1:0] grp_q;
  logic [1:0] run_grp_q;
  logic secondary_trigger_select_q;
  logic tmr_sel_q;
  logic cnt_sel_q;
  logic irq_st_q;
  logic irq_mask_q;
  adcss_state_t state_q;
  logic [CW-1:0] ch_q;
  logic [CW-1:0] fav_q;
  logic [CW-1:0] other_q;
  logic fav_turn_q;
  logic pin_q;
  logic pin_prev_q;
  logic rd_mem_q;
  logic rd_q;
  logic [DATA_W-1:0] rd_reg_q;
  logic sweep_end;
  logic start_wr;
  logic stop_wr;
  logic hw_event;
  logic [CW-1:0] last_ch;
  logic [CW-1:0] fav_last;
  logic [RES_W-1:0] mem_rdata;
  logic [CW-1:0] mem_rd_idx;
  logic wr_ctrl0;

  assign wr_ctrl0 = reg_wr && reg_addr == OFS_CTRL0;
  assign start_wr = wr_ctrl0 && reg_wdata[B_START];
  assign stop_wr = wr_ctrl0 && !reg_wdata[B_START];
  // scan width: 2,4,6,8 channels sweep; 1..4 favoured in repeat sweep 1
  assign last_ch = CW'({scan_q, 1'b1}); // RULE4 RULE10
  assign fav_last = CW'(scan_q); // RULE6

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge
  adcss_sync #(.W(1)) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(external_trigger_pin_n),
    .q(pin_q)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= pin_q;
    end
  end

  // hardware source decode; pin only without timer select outside simul
  always_comb begin
    hw_event = pin_prev_q && !pin_q; // RULE2
    if (mode_q == MODE_SIMUL) begin
      if (tmr_sel_q) begin
        hw_event = first_timer_uf; // RULE12 RULE14
      end else if (secondary_trigger_select_q) begin
        hw_event = cnt_sel_q ? freq_counter_uf : third_timer_uf; // RULE14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_q <= 1'b0;
      trg_q <= 1'b0;
    end else if (wr_ctrl0) begin
      start_q <= reg_wdata[B_START];
      trg_q <= reg_wdata[B_TRG];
    end else if (sweep_end && !trg_q) begin
      start_q <= 1'b0; // RULE11
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_q <= MODE_REP0;
      scan_q <= 2'h0;
      grp_q <= 2'h0;
      secondary_trigger_select_q <= 1'b0;
      tmr_sel_q <= 1'b0;
      cnt_sel_q <= 1'b0;
      irq_mask_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CTRL1) begin
        mode_q <= reg_wdata[B_MODE_HI:B_MODE_LO];
        scan_q <= reg_wdata[B_SCAN_HI:B_SCAN_LO];
      end
      if (reg_addr == OFS_CTRL2) begin
        grp_q <= reg_wdata[B_GRP_HI:B_GRP_LO];
      end
      if (reg_addr == OFS_TRGCON) begin
        secondary_trigger_select_q <= reg_wdata[B_SECONDARY_TRIGGER_SELECT];
        tmr_sel_q <= reg_wdata[B_TMR_SEL];
        cnt_sel_q <= reg_wdata[B_CNT_SEL];
      end
      if (reg_addr == OFS_IRQ_MASK) begin
        irq_mask_q <= reg_wdata[B_IRQ_DONE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  assign sweep_end = state_q == ADCSS_WAIT && conv_done && !stop_wr
    && mode_q == MODE_SIMUL && ch_q == last_ch; // RULE10 RULE11

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ADCSS_IDLE;
      ch_q <= '0;
      fav_q <= '0;
      other_q <= '0;
      fav_turn_q <= 1'b1;
    end else if (stop_wr) begin
      state_q <= ADCSS_IDLE; // RULE3 RULE15
    end else begin
      unique case (state_q)
        ADCSS_IDLE: begin
          ch_q <= '0;
          fav_q <= '0;
          other_q <= fav_last + CW'(1);
          fav_turn_q <= 1'b1;
          if (start_wr) begin
            // underflows before arming are not seen here
            state_q <= reg_wdata[B_TRG] ? ADCSS_ARMED : ADCSS_CONV; // RULE1
          end
        end
        ADCSS_ARMED: begin
          if (hw_event) begin
            state_q <= ADCSS_CONV; // RULE2 RULE13
          end
        end
        ADCSS_CONV: begin
          state_q <= ADCSS_WAIT;
        end
        ADCSS_WAIT: begin
          if (conv_done) begin
            state_q <= ADCSS_CONV;
            unique case (mode_q)
              MODE_REP1: begin
                // RULE5: favoured, other, favoured, next other
                if (fav_turn_q) begin
                  ch_q <= other_q;
                  fav_q <= (fav_q == fav_last) ? '0 : fav_q + CW'(1);
                end else begin
                  ch_q <= fav_q;
                  other_q <= (other_q == CW'(NCHAN - 1))
                    ? fav_last + CW'(1) : other_q + CW'(1);
                end
                fav_turn_q <= !fav_turn_q; // RULE5
              end
              MODE_SIMUL: begin
                ch_q <= ch_q + CW'(1);
                if (ch_q == last_ch) begin
                  state_q <= ADCSS_IDLE; // RULE11
                end
              end
              default: begin
                ch_q <= (ch_q == last_ch) ? '0 : ch_q + CW'(1); // RULE4 RULE3
              end
            endcase
          end
        end
      endcase
    end
  end

  // group frozen while a conversion runs: a mid-sweep write to the group
  // field waits for the next start, so one sweep never mixes two groups
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_grp_q <= 2'h0;
    end else if (state_q == ADCSS_IDLE || state_q == ADCSS_ARMED) begin
      run_grp_q <= grp_q; // RULE7
    end
  end

  assign conv_start = state_q == ADCSS_CONV;
  assign conv_channel = 3'(ch_q);
  assign conv_group = run_grp_q; // RULE7
  // both sample-holds take channels 0 and 1 at the first conversion
  assign sample_hold_pair = conv_start && mode_q == MODE_SIMUL
    && ch_q == '0; // RULE9

  ////////////////////////////////////////////////////////////////////////
  // results and interrupt
  assign mem_rd_idx = CW'(reg_addr - OFS_RESULT0);

  adcss_result_mem #(.N(NCHAN), .W(RES_W)) u_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(state_q == ADCSS_WAIT && conv_done && !stop_wr), // RULE8 RULE15
    .wr_idx(ch_q),
    .wr_data(conv_result),
    .rd_idx(mem_rd_idx),
    .rd_data(mem_rdata)
  );

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_st_q <= 1'b0;
    end else if (sweep_end) begin
      irq_st_q <= 1'b1; // RULE11 RULE16
    end else if (reg_wr && reg_addr == OFS_IRQ_ST
      && reg_wdata[B_IRQ_DONE]) begin
      irq_st_q <= 1'b0;
    end
  end

  assign irq = irq_st_q && irq_mask_q;

  ////////////////////////////////////////////////////////////////////////
  // read port: data stand one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_q <= 1'b0;
      rd_mem_q <= 1'b0;
      rd_reg_q <= '0;
    end else begin
      rd_q <= reg_rd;
      rd_mem_q <= reg_rd && reg_addr >= OFS_RESULT0;
      rd_reg_q <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          OFS_CTRL0: rd_reg_q <= DATA_W'({trg_q, start_q});
          OFS_CTRL1: rd_reg_q <= DATA_W'({scan_q, mode_q});
          OFS_CTRL2: rd_reg_q <= DATA_W'(grp_q);
          OFS_TRGCON: rd_reg_q <= DATA_W'({cnt_sel_q, tmr_sel_q, secondary_trigger_select_q});
          OFS_STATUS: rd_reg_q <= DATA_W'({ch_q, state_q});
          OFS_IRQ_ST: rd_reg_q <= DATA_W'(irq_st_q);
          OFS_IRQ_MASK: rd_reg_q <= DATA_W'(irq_mask_q);
          default: rd_reg_q <= '0;
        endcase
      end
    end
  end

  assign reg_rdata = !rd_q ? '0 : rd_mem_q ? DATA_W'(mem_rdata) : rd_reg_q;
endmodule : adcss_top

// >>> adcss_pkg.sv
// adcss_pkg: register map, field positions and modes of the sweep sequencer
// assumes a plain one-cycle register port and an external conversion core
package adcss_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int RES_W = 10;
  localparam int NCH = 8;

  // register word offsets, one 16-bit register per address
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL2 = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_TRGCON = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_RESULT0 = 4'h8;

  // converter_control_0 fields
  localparam int B_START = 0;
  localparam int B_TRG = 1;
  // converter_control_1 fields: mode and scan width
  localparam int B_MODE_LO = 0;
  localparam int B_MODE_HI = 1;
  localparam int B_SCAN_LO = 2;
  localparam int B_SCAN_HI = 3;
  // converter_control_2 fields: channel group
  localparam int B_GRP_LO = 0;
  localparam int B_GRP_HI = 1;
  // trigger_control_reg fields
  localparam int B_SECONDARY_TRIGGER_SELECT = 0;
  localparam int B_TMR_SEL = 1;
  localparam int B_CNT_SEL = 2;
  // interrupt status bits
  localparam int B_IRQ_DONE = 0;

  localparam logic [1:0] MODE_REP0 = 2'h0;
  localparam logic [1:0] MODE_REP1 = 2'h1;
  localparam logic [1:0] MODE_SIMUL = 2'h2;

  typedef enum logic [1:0] {
    ADCSS_IDLE = 2'b00,
    ADCSS_ARMED = 2'b01,
    ADCSS_CONV = 2'b10,
    ADCSS_WAIT = 2'b11
  } adcss_state_t;
endpackage : adcss_pkg

// >>> adcss_sync.sv
// adcss_sync: two-flop synchroniser for asynchronous pin levels
// assumes the input is a slow level from outside the clk_sys domain
`timescale 1ns/1ps
module adcss_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first flop feeds only the second one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '1;
      q <= '1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : adcss_sync

// >>> adcss_result_mem.sv
// adcss_result_mem: per-channel result store with registered read port
// assumes one write and one read per cycle at most
`timescale 1ns/1ps
module adcss_result_mem #(
  parameter int N = 8,
  parameter int W = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [$clog2(N)-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [$clog2(N)-1:0] rd_idx,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_q [N];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_q[rd_idx];
    end
  end
endmodule : adcss_result_mem

// >>> adcss_core_model.sv
// adcss_core_model: behavioural conversion core beside the sequencer
// assumes one-cycle conv_start pulses on clk_sys; lat sets the answer delay
`timescale 1ns/1ps
module adcss_core_model
  import adcss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic [2:0] conv_channel,
  input wire logic [1:0] conv_group,
  input wire logic [7:0] lat,
  output logic conv_done,
  output logic [RES_W-1:0] conv_result
);
  ////////////////////////////////////////////////////////////
  logic [7:0] cnt_q;
  logic [RES_W-1:0] last_q;

  // result carries group and channel, so a misrouted store shows
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= 8'h00;
      last_q <= '0;
      conv_done <= 1'b0;
      conv_result <= '0;
    end else if (!conv_start && cnt_q == 8'h01) begin
      cnt_q <= 8'h00;
      conv_done <= 1'b1;
      conv_result <= {conv_group, 5'h15, conv_channel};
      last_q <= {conv_group, 5'h15, conv_channel};
    end else begin
      cnt_q <= conv_start ? lat
        : (cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01;
      conv_done <= 1'b0;
      // not held outside done: a stale read would pass otherwise
      conv_result <= ~last_q;
    end
  end
endmodule : adcss_core_model

// >>> adcss_assertions.sv
// adcss_assertions: port-level checks of the sweep sequencer
// assumes binding to adcss_top; one clock, sync active-high reset
`timescale 1ns/1ps
module adcss_checker
  import adcss_pkg::*;
#(
  parameter int NCHAN = NCH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic external_trigger_pin_n,
  input wire logic first_timer_uf,
  input wire logic third_timer_uf,
  input wire logic freq_counter_uf,
  input wire logic conv_start,
  input wire logic [2:0] conv_channel,
  input wire logic [1:0] conv_group,
  input wire logic sample_hold_pair,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  logic ctl_wr;
  assign ctl_wr = reg_wr && reg_addr == OFS_CTRL0;

  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == '0) else $error("stray read data");
  unmapped_rd_a: assert property (
    reg_rd && reg_addr == 4'h7 |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  sw_start_a: assert property (
    $past(ctl_wr && !reg_wdata[B_START]) && ctl_wr && reg_wdata[B_START]
    && !reg_wdata[B_TRG] |=> conv_start) else $error("no start");
  abort_quiet_a: assert property (
    ctl_wr && !reg_wdata[B_START] |=> !conv_start)
    else $error("start after abort");
  start_pulse_a: assert property (
    conv_start |=> !conv_start) else $error("start not a pulse");
  chan_hold_a: assert property (
    conv_start |=> $stable(conv_channel) && $stable(conv_group))
    else $error("channel moved");
  pair_ch0_a: assert property (
    sample_hold_pair |-> conv_start && conv_channel == 3'h0)
    else $error("pair sample off channel 0");
  irq_mask_a: assert property (
    reg_wr && reg_addr == OFS_IRQ_MASK && !reg_wdata[B_IRQ_DONE] |=> !irq)
    else $error("masked irq high");
  irq_clear_a: assert property (
    reg_wr && reg_addr == OFS_IRQ_ST && reg_wdata[B_IRQ_DONE] && !conv_done
    && !$past(conv_done) |=> !irq) else $error("irq not cleared");
endmodule : adcss_checker

bind adcss_top adcss_checker #(.NCHAN(NCHAN)) chk_u (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .external_trigger_pin_n(external_trigger_pin_n),
  .first_timer_uf(first_timer_uf), .third_timer_uf(third_timer_uf),
  .freq_counter_uf(freq_counter_uf), .conv_start(conv_start),
  .conv_channel(conv_channel), .conv_group(conv_group),
  .sample_hold_pair(sample_hold_pair), .conv_done(conv_done),
  .conv_result(conv_result), .irq(irq)
);

// >>> test_adc_sweep_sequencer.sv
// test_adc_sweep_sequencer: register-level tests of the sweep sequencer
// assumes adcss_top with the behavioural core model on its far side
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %h got %h", n, e, g); num_errors++; end end
module test_adc_sweep_sequencer
  import adcss_pkg::*;
;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, pin_n = 1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic [2:0] uf = 3'h0, conv_channel;
  logic [7:0] lat = 8'h03;
  logic [1:0] conv_group, mode = MODE_REP0, grp = 2'h0;
  logic conv_start, shp, conv_done, irq;
  logic [RES_W-1:0] conv_result;
  logic [2:0] tsel [4] = '{3'h0, 3'h2, 3'h1, 3'h5};
  logic [2:0] seq [$];
  int num_errors = 0, check_count = 0;
  ////////////////////////////////////////////////////////////
  adcss_top dut_u (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_trigger_pin_n(pin_n),
    .first_timer_uf(uf[0]), .third_timer_uf(uf[1]),
    .freq_counter_uf(uf[2]), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_group(conv_group),
    .sample_hold_pair(shp), .conv_done(conv_done),
    .conv_result(conv_result), .irq(irq));
  adcss_core_model core_u (
    .clk_sys(clk_sys), .rst(rst), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_group(conv_group), .lat(lat),
    .conv_done(conv_done), .conv_result(conv_result));
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (conv_start) begin
    seq.push_back(conv_channel);
    `CHK("pair", conv_channel == 3'h0 && mode == MODE_SIMUL, shp)
    `CHK("group", grp, conv_group)
  end
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // stop then start back to back, so the sequencer leaves idle fresh
  task automatic start(input logic [1:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= OFS_CTRL0;
    reg_wdata <= 16'h0000;
    @(posedge clk_sys);
    reg_wdata <= {14'h0, v};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : start
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    `CHK($sformatf("reg %h", a), e, reg_rdata)
  endtask : rc
  task automatic wait_n(input int n);
    int t;
    t = 0;
    while (seq.size() < n && t < 3000) begin
      @(posedge clk_sys);
      t++;
    end
    `CHK("count", 1'b1, seq.size() >= n)
  endtask : wait_n
  task automatic wait_irq(input logic v);
    int t;
    t = 0;
    while (irq !== v && t < 300) begin
      @(posedge clk_sys);
      t++;
    end
    `CHK("irq", v, irq)
  endtask : wait_irq
  task automatic fire(input int k);
    @(posedge clk_sys);
    if (k == 0) pin_n <= 1'b0;
    else uf[k-1] <= 1'b1;
    @(posedge clk_sys);
    uf <= 3'h0;
    repeat (4) @(posedge clk_sys);
    pin_n <= 1'b1;
  endtask : fire
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////
  initial begin
    #3_000_000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rc(a[3:0], 16'h0000);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      grp = s[1:0];
      wr(OFS_CTRL2, {14'h0, grp});
      wr(OFS_CTRL1, {12'h0, s[1:0], MODE_REP0});
      seq.delete();
      start(2'b01);
      wait_n(4 * s + 4);
      wr(OFS_CTRL0, 16'h0000);
      for (int i = 0; i < 4 * s + 4; i++)
        `CHK("rep0", i % (2 * s + 2), seq[i])
      for (int k = 0; k < 2 * s + 2; k++)
        rc(OFS_RESULT0 + k[3:0], {6'h0, grp, 5'h15, k[2:0]});
      rc(OFS_IRQ_ST, 16'h0000);
    end
    $display("test repeat sweep 0 done");
    mode = MODE_REP1;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL1, {12'h0, s[1:0], MODE_REP1});
      seq.delete();
      start(2'b01);
      wait_n(20);
      wr(OFS_CTRL0, 16'h0000);
      for (int i = 0; i < 20; i += 2) begin
        `CHK("fav", 1'b1, seq[i] <= s)
        `CHK("other", s + 1 + (i / 2) % (7 - s), seq[i + 1])
      end
      rc(OFS_IRQ_ST, 16'h0000);
    end
    $display("test repeat sweep 1 done");
    mode = MODE_SIMUL;
    wr(OFS_CTRL1, {12'h0, 2'h3, MODE_SIMUL});
    seq.delete();
    start(2'b01);
    repeat (60) @(posedge clk_sys);
    `CHK("simul n", 8, seq.size())
    for (int i = 0; i < 8; i++) `CHK("simul", i, seq[i])
    rc(OFS_CTRL0, 16'h0000);
    rc(OFS_IRQ_ST, 16'h0001);
    `CHK("masked", 1'b0, irq)
    wr(OFS_IRQ_MASK, 16'h0001);
    wait_irq(1'b1);
    wr(OFS_IRQ_MASK, 16'h0000);
    wait_irq(1'b0);
    rc(OFS_IRQ_ST, 16'h0001);
    wr(OFS_IRQ_MASK, 16'h0001);
    wait_irq(1'b1);
    wr(OFS_IRQ_ST, 16'h0001);
    wait_irq(1'b0);
    $display("test simultaneous sweep done");
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL1, {12'h0, 2'h0, MODE_SIMUL});
      wr(OFS_TRGCON, {13'h0, tsel[k]});
      fire(k);
      repeat (5) @(posedge clk_sys);
      seq.delete();
      start(2'b11);
      for (int j = 0; j < 4; j++) if (j != k) fire(j);
      repeat (8) @(posedge clk_sys);
      `CHK("early", 0, seq.size())
      fire(k);
      wait_irq(1'b1);
      `CHK("hw n", 2, seq.size())
      wr(OFS_CTRL0, 16'h0000);
      wr(OFS_IRQ_ST, 16'h0001);
      wait_irq(1'b0);
    end
    $display("test hardware triggers done");
    mode = MODE_REP0;
    wr(OFS_CTRL1, 16'h0000);
    wr(OFS_TRGCON, 16'h0002);
    seq.delete();
    start(2'b11);
    fire(1);
    repeat (8) @(posedge clk_sys);
    `CHK("rep armed", 0, seq.size())
    fire(0);
    wait_n(4);
    wr(OFS_CTRL0, 16'h0000);
    for (int i = 0; i < 4; i++) `CHK("rep hw", i % 2, seq[i])
    $display("test repeat hardware trigger done");
    mode = MODE_REP0;
    grp = 2'h2;
    wr(OFS_CTRL2, 16'h0002);
    wr(OFS_CTRL1, 16'h0000);
    lat <= 8'h28;
    seq.delete();
    start(2'b01);
    wait_n(1);
    repeat (5) @(posedge clk_sys);
    wr(OFS_CTRL0, 16'h0000);
    repeat (60) @(posedge clk_sys);
    `CHK("abort n", 1, seq.size())
    rc(OFS_RESULT0, {6'h0, 2'h3, 5'h15, 3'h0});
    $display("test abort done");
    conclude();
  end
endmodule : test_adc_sweep_sequencer
